/* File: src/pack_guard_pkg.sv */
/*
 * shared constants for the pack voltage fault reaction pair:
 * sample widths, link timing counts and pwm settings.
 * assumes a single 10 mhz core clock on both ends.
 */
package pack_guard_pkg;
	localparam int VOLT_W = 16;
	localparam int CLK_MHZ = 10;
	// time given to layer one to open before the fuse is used
	localparam int LAYER_WAIT_US = 1000;
	localparam int LAYER_WAIT_CYC = LAYER_WAIT_US * CLK_MHZ;
	// controller must toggle its heartbeat within this time
	localparam int WDOG_US = 2000;
	localparam int WDOG_CYC = WDOG_US * CLK_MHZ;
	// monitor conversion interval
	localparam int CONV_CYC = 16;
	localparam int PWM_W = 8;
	localparam logic [PWM_W-1:0] PWM_DUTY_RST = 8'hff;
	localparam logic [VOLT_W-1:0] OV_RST = 16'hf000;
	localparam logic [VOLT_W-1:0] UV_RST = 16'h1000;
	// fine reading carries four extra bits
	localparam int FINE_EXTRA = 4;
endpackage

/* File: src/pack_guard_if.sv */
/*
 * pin level link between the pack monitor and its controller.
 * assumes both ends sit on the same core clock; no clocking block.
 */
`timescale 1ns/100ps
interface pack_guard_if;
	import pack_guard_pkg::*;
	logic protect_request_a;
	logic protect_request_b;
	logic fuse_blow_cmd;
	logic sense_alert_irq;
	logic ctrl_reset_n;
	logic monitor_reset_n;
	logic heartbeat;
	logic layer_open;
	logic [VOLT_W+FINE_EXTRA-1:0] pack_volt_fine;
	modport monitor (
		input protect_request_a, protect_request_b, monitor_reset_n, heartbeat,
		output sense_alert_irq, ctrl_reset_n, layer_open, pack_volt_fine
	);
	modport ctrl (
		output protect_request_a, protect_request_b, fuse_blow_cmd, monitor_reset_n,
		heartbeat,
		input sense_alert_irq, ctrl_reset_n, layer_open, pack_volt_fine
	);
endinterface

/* File: src/limit_window.sv */
/*
 * registered over and under limit compare of one voltage sample.
 * assumes sample and limits are on the core clock.
 */
`timescale 1ns/100ps
module limit_window import pack_guard_pkg::*; #(
	parameter int W = VOLT_W
) (
	input wire logic clk, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic [W-1:0] sample, // voltage sample
	input wire logic [W-1:0] over_lim, // over limit
	input wire logic [W-1:0] under_lim, // under limit
	output logic fault // either limit crossed
);
	logic fault_d;
	always_comb begin
		fault_d = (sample > over_lim) || (sample < under_lim);
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault <= 1'b0;
		end else begin
			fault <= fault_d;
		end
	end
endmodule

/* File: src/pack_monitor.sv */
/*
 * monitor end: converts pack voltage, opens layer one on limit
 * crossings or controller requests, raises an alert, and watches the
 * controller heartbeat. assumes adc input and limits are static pins.
 */
`timescale 1ns/100ps
module pack_monitor import pack_guard_pkg::*; #(
	parameter int WDOG_COUNT = WDOG_CYC
) (
	input wire logic CORE_CLK, // core clock
	input wire logic RESETN, // async reset, active low
	pack_guard_if.monitor LINK, // link to controller
	input wire logic [VOLT_W+FINE_EXTRA-1:0] ADC_RAW, // raw converter value
	input wire logic [VOLT_W-1:0] OVER_LIM, // over limit
	input wire logic [VOLT_W-1:0] UNDER_LIM, // under limit
	input wire logic IRQ_CLEAR, // clear alert, one cycle
	output logic LAYER_OPEN, // layer one opened
	output logic [VOLT_W-1:0] PACK_VOLT_INTERNAL // coarse reading
);
	logic [1:0] rst_sync_q, req_a_sync_q, req_b_sync_q, hb_sync_q;
	logic [VOLT_W+FINE_EXTRA-1:0] fine_q, fine_d;
	logic [VOLT_W-1:0] coarse_q, coarse_d;
	logic [4:0] conv_q, conv_d;
	logic [$clog2(WDOG_COUNT+1)-1:0] wd_q, wd_d;
	logic hb_prev_q, open_q, open_d, alert_q, alert_d, wdr_q, wdr_d, limit_fault;
	logic mon_rst_n;
	logic [1:0] vld_q, vld_d;
	logic lim_hit;
	// shutdown line resets this end
	assign mon_rst_n = RESETN & rst_sync_q[1];
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_sync_q <= 2'b11; // idle high, no shutdown at start
			req_a_sync_q <= 2'b11;
			req_b_sync_q <= 2'b11;
			hb_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], LINK.monitor_reset_n};
			req_a_sync_q <= {req_a_sync_q[0], LINK.protect_request_a};
			req_b_sync_q <= {req_b_sync_q[0], LINK.protect_request_b};
			hb_sync_q <= {hb_sync_q[0], LINK.heartbeat};
		end
	end
	limit_window #(.W(VOLT_W)) u_win (
		.clk(CORE_CLK),
		.rst_n(mon_rst_n),
		.sample(coarse_q),
		.over_lim(OVER_LIM),
		.under_lim(UNDER_LIM),
		.fault(limit_fault)
	);
	always_comb begin
		conv_d = (conv_q == 5'(CONV_CYC - 1)) ? 5'h00 : conv_q + 5'h01;
		fine_d = fine_q;
		coarse_d = coarse_q;
		if (conv_q == 5'h00) begin
			fine_d = ADC_RAW;
			coarse_d = ADC_RAW[VOLT_W+FINE_EXTRA-1:FINE_EXTRA];
		end
		// own compare or either request low opens layer one; the
		// controller's low requests open even through a reset of this end
		// first compare waits for a real sample, not the reset zero
		vld_d = {vld_q[0], 1'b1};
		lim_hit = limit_fault & vld_q[1];
		open_d = open_q | lim_hit;
		alert_d = (alert_q & ~IRQ_CLEAR) | (lim_hit & ~open_q);
		wd_d = wd_q + 1'b1;
		wdr_d = 1'b1;
		if (hb_sync_q[1] != hb_prev_q) begin
			wd_d = '0;
		end else if (wd_q == ($bits(wd_q))'(WDOG_COUNT - 1)) begin
			wd_d = '0;
			wdr_d = 1'b0;
		end
	end
	always_ff @(posedge CORE_CLK or negedge mon_rst_n) begin
		if (!mon_rst_n) begin
			conv_q <= 5'h00;
			vld_q <= 2'b00;
			fine_q <= '0;
			coarse_q <= '0;
			open_q <= 1'b0;
			alert_q <= 1'b0;
			wd_q <= '0;
			wdr_q <= 1'b1;
			hb_prev_q <= 1'b0;
		end else begin
			conv_q <= conv_d;
			vld_q <= vld_d;
			fine_q <= fine_d;
			coarse_q <= coarse_d;
			open_q <= open_d;
			alert_q <= alert_d;
			wd_q <= wd_d;
			wdr_q <= wdr_d;
			hb_prev_q <= hb_sync_q[1];
		end
	end
	logic pin_open_q;
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			pin_open_q <= 1'b0;
		end else begin
			pin_open_q <= open_d | ~mon_rst_n | ~req_a_sync_q[1] | ~req_b_sync_q[1];
		end
	end
	assign LAYER_OPEN = pin_open_q;
	assign LINK.layer_open = pin_open_q;
	assign PACK_VOLT_INTERNAL = coarse_q;
	assign LINK.pack_volt_fine = fine_q;
	assign LINK.sense_alert_irq = alert_q;
	assign LINK.ctrl_reset_n = wdr_q;
endmodule

/* File: src/pack_controller.sv */
/*
 * controller end: compares its own pack reading, requests layer one,
 * blows the fuse with a pwm heater drive if layer one stays closed,
 * and exposes a small register port. assumes link pins are async.
 */
// Overview of operation
// - monitor opens layer one past either limit
// - monitor keeps coarse and fine pack readings
// - controller compares own reading with both limits
// - controller fault drives both request lines low
// - layer still closed after wait blows fuse
// - fuse only after layer one fails
// - heater driven by adjustable pwm duty
// - monitor raises alert line on sensing events
// - monitor watchdog resets the controller
// - controller can reset monitor via shutdown
// - link is direct parallel pins only, no serial path
// - no standby command ever issued
// - no pre-charge sequence exists
`timescale 1ns/100ps
module pack_controller import pack_guard_pkg::*; #(
	parameter int WAIT_COUNT = LAYER_WAIT_CYC
) (
	input wire logic CORE_CLK, // core clock
	input wire logic RESETN, // async reset, active low
	pack_guard_if.ctrl LINK, // link to monitor
	input wire logic [VOLT_W-1:0] PACK_VOLT_CTRL, // own divider reading
	input wire logic [3:0] ADDR, // register address
	input wire logic [31:0] WDATA, // write data
	input wire logic WR, // write strobe
	input wire logic RD, // read strobe
	output logic [31:0] RDATA, // read data, cycle after RD
	output logic IRQ, // enabled status pending
	output logic HEATER_PWM // fuse heater drive
);
	localparam logic [3:0] A_OVER = 4'h0;
	localparam logic [3:0] A_UNDER = 4'h1;
	localparam logic [3:0] A_DUTY = 4'h2;
	localparam logic [3:0] A_CTRL = 4'h3;
	localparam logic [3:0] A_STAT = 4'h4;
	localparam logic [3:0] A_CLR = 4'h5;
	localparam logic [3:0] A_EN = 4'h6;
	localparam logic [3:0] A_FINE = 4'h7;
	localparam logic [3:0] A_STATE = 4'h8;
	typedef enum logic [1:0] {IDLE, WAIT_OPEN, BLOW} state_t;
	state_t st_q, st_d;
	logic [VOLT_W-1:0] over_q, over_d, under_q, under_d;
	logic [PWM_W-1:0] duty_q, duty_d, pwm_q, pwm_d;
	logic [$clog2(WAIT_COUNT+1)-1:0] wt_q, wt_d;
	logic [3:0] stat_q, stat_d, en_q, en_d;
	logic [31:0] rdata_q, rdata_d;
	logic req_q, req_d, fuse_q, fuse_d, heat_q, heat_d, irq_q, irq_d;
	logic shdn_q, shdn_d, hb_q, hb_d, fault;
	logic [1:0] open_s_q, alert_s_q, wdr_s_q;
	logic [VOLT_W+FINE_EXTRA-1:0] fine_s1_q, fine_s2_q;
	logic alert_prev_q, open_prev_q, rst_n;
	// monitor watchdog resets this end
	assign rst_n = RESETN & wdr_s_q[1];
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			open_s_q <= 2'b00;
			alert_s_q <= 2'b00;
			wdr_s_q <= 2'b00;
			fine_s1_q <= '0;
			fine_s2_q <= '0;
		end else begin
			open_s_q <= {open_s_q[0], LINK.layer_open};
			alert_s_q <= {alert_s_q[0], LINK.sense_alert_irq};
			wdr_s_q <= {wdr_s_q[0], LINK.ctrl_reset_n};
			// fine word: both ends share the core clock, so no gray code
			fine_s1_q <= LINK.pack_volt_fine;
			fine_s2_q <= fine_s1_q;
		end
	end
	limit_window #(.W(VOLT_W)) u_win (
		.clk(CORE_CLK),
		.rst_n(rst_n),
		.sample(PACK_VOLT_CTRL),
		.over_lim(over_q),
		.under_lim(under_q),
		.fault(fault)
	);
	always_comb begin
		over_d = over_q;
		under_d = under_q;
		duty_d = duty_q;
		en_d = en_q;
		shdn_d = shdn_q;
		hb_d = hb_q;
		// status: 0 fault, 1 fuse fired, 2 alert edge, 3 layer open
		stat_d = stat_q;
		if (WR && ADDR == A_CLR) begin
			stat_d = stat_q & ~WDATA[3:0];
		end
		if (WR) begin
			unique case (ADDR)
				A_OVER: over_d = WDATA[VOLT_W-1:0];
				A_UNDER: under_d = WDATA[VOLT_W-1:0];
				A_DUTY: duty_d = WDATA[PWM_W-1:0];
				A_CTRL: begin
					hb_d = hb_q ^ WDATA[0];
					shdn_d = WDATA[1];
				end
				A_EN: en_d = WDATA[3:0];
				default: ;
			endcase
		end
		rdata_d = 32'h0;
		if (RD) begin
			unique case (ADDR)
				A_OVER: rdata_d = 32'(over_q);
				A_UNDER: rdata_d = 32'(under_q);
				A_DUTY: rdata_d = 32'(duty_q);
				A_CTRL: rdata_d = {30'h0, shdn_q, hb_q};
				A_STAT: rdata_d = 32'(stat_q);
				A_EN: rdata_d = 32'(en_q);
				A_FINE: rdata_d = 32'(fine_s2_q);
				A_STATE: rdata_d = 32'(st_q);
				default: rdata_d = 32'h0;
			endcase
		end
		st_d = st_q;
		req_d = req_q;
		fuse_d = fuse_q;
		wt_d = wt_q;
		unique case (st_q)
			IDLE: if (fault) begin
				req_d = 1'b1;
				wt_d = '0;
				st_d = WAIT_OPEN;
			end
			WAIT_OPEN: if (open_s_q[1]) begin
				st_d = WAIT_OPEN;
			end else if (wt_q == ($bits(wt_q))'(WAIT_COUNT - 1)) begin
				fuse_d = 1'b1;
				st_d = BLOW;
			end else begin
				wt_d = wt_q + 1'b1;
			end
			BLOW: st_d = BLOW;
			// a corrupt state code falls back to requesting layer one
			default: begin
				req_d = 1'b1;
				wt_d = '0;
				st_d = WAIT_OPEN;
			end
		endcase
		// only events set status, so a clear holds once the cause is seen
		stat_d = stat_d | {open_s_q[1] & ~open_prev_q, alert_s_q[1] & ~alert_prev_q,
			fuse_d & ~fuse_q, req_d & ~req_q};
		irq_d = |(stat_d & en_d);
		pwm_d = pwm_q + 1'b1;
		// duty of all ones drives the heater steadily
		heat_d = fuse_d && (pwm_q < duty_q || duty_q == PWM_DUTY_RST);
	end
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= IDLE;
			over_q <= OV_RST;
			under_q <= UV_RST;
			duty_q <= PWM_DUTY_RST;
			pwm_q <= '0;
			wt_q <= '0;
			stat_q <= 4'h0;
			en_q <= 4'h0;
			rdata_q <= 32'h0;
			req_q <= 1'b0;
			fuse_q <= 1'b0;
			heat_q <= 1'b0;
			irq_q <= 1'b0;
			shdn_q <= 1'b0;
			hb_q <= 1'b0;
			alert_prev_q <= 1'b0;
			open_prev_q <= 1'b0;
		end else begin
			st_q <= st_d;
			over_q <= over_d;
			under_q <= under_d;
			duty_q <= duty_d;
			pwm_q <= pwm_d;
			wt_q <= wt_d;
			stat_q <= stat_d;
			en_q <= en_d;
			rdata_q <= rdata_d;
			req_q <= req_d;
			fuse_q <= fuse_d;
			heat_q <= heat_d;
			irq_q <= irq_d;
			shdn_q <= shdn_d;
			hb_q <= hb_d;
			alert_prev_q <= alert_s_q[1];
			open_prev_q <= open_s_q[1];
		end
	end
	// both lines low together; no standby or pre-charge outputs exist
	assign LINK.protect_request_a = ~req_q;
	assign LINK.protect_request_b = ~req_q;
	assign LINK.fuse_blow_cmd = fuse_q;
	assign LINK.monitor_reset_n = ~shdn_q;
	assign LINK.heartbeat = hb_q;
	assign RDATA = rdata_q;
	assign IRQ = irq_q;
	assign HEATER_PWM = heat_q;
endmodule

/* File: verification/pack_guard_chk.sv */
/* assertions on the link between pack monitor and controller.
   assumes one core clock and an async active low reset. */
`timescale 1ns/100ps
module pack_guard_chk import pack_guard_pkg::*; #(
	parameter int WDOG_COUNT = WDOG_CYC
) (
	input wire logic CORE_CLK, // clock
	input wire logic RESETN, // reset
	input wire logic protect_request_a, // request a
	input wire logic protect_request_b, // request b
	input wire logic fuse_blow_cmd, // fuse
	input wire logic sense_alert_irq, // alert
	input wire logic ctrl_reset_n, // watchdog reset
	input wire logic monitor_reset_n, // shutdown
	input wire logic heartbeat, // heartbeat
	input wire logic layer_open // layer one open
);
	int cnt_q, cnt_d;
	logic hb_q;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	// cycles since the heartbeat last moved
	always_comb begin
		cnt_d = (heartbeat != hb_q || !ctrl_reset_n || !monitor_reset_n) ? 0 : cnt_q + 1;
	end
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			cnt_q <= 0;
			hb_q <= 1'h0;
		end else begin
			cnt_q <= cnt_d;
			hb_q <= heartbeat;
		end
	end
	sequence req_fall_s;
		$fell(protect_request_a);
	endsequence
	sequence open_soon_s;
		##[1:6] layer_open;
	endsequence
	req_pair_a: assert property (protect_request_a == protect_request_b)
		else $error("request lines differ");
	req_open_a: assert property (req_fall_s |-> open_soon_s)
		else $error("layer one stayed closed");
	req_hold_a: assert property (!protect_request_a |=> !protect_request_a)
		else $error("request released");
	fuse_hold_a: assert property (fuse_blow_cmd |=> fuse_blow_cmd)
		else $error("fuse command released");
	fuse_late_a: assert property ($rose(fuse_blow_cmd) |-> !layer_open && !protect_request_a)
		else $error("fuse without layer failure");
	alert_open_a: assert property ($rose(sense_alert_irq) |-> ##[0:4] layer_open)
		else $error("alert without layer open");
	shut_open_a: assert property (!monitor_reset_n [*2] |-> ##[0:4] layer_open)
		else $error("shutdown left layer closed");
	wdog_late_a: assert property (cnt_q <= WDOG_COUNT + 4)
		else $error("watchdog did not fire");
	wdog_early_a: assert property ($fell(ctrl_reset_n) |-> cnt_q >= WDOG_COUNT - 4)
		else $error("watchdog fired early");
endmodule

/* File: verification/test_pack_voltage_fault_reaction.sv */
/* bench: monitor and controller on one link, plus a second controller
   facing a stub whose layer one never opens. assumes src compiled first. */
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
	$display("ERROR %0t got %h exp %h", $time, a, b); end end
`define WAITV(s, v, n) for (int i = 0; i < n && (s) !== v; i++) @(negedge CORE_CLK);
module test_pack_voltage_fault_reaction import pack_guard_pkg::*;;
	localparam int WD = 2000;
	logic CORE_CLK = 1'h0, RESETN = 1'h0, IRQ_CLEAR = 1'h0, WR = 1'h0, RD = 1'h0, rd_q = 1'h0;
	logic LAYER_OPEN, IRQ, IRQ2, HEATER_PWM, HEATER_PWM2;
	logic [19:0] ADC_RAW = 20'h80000;
	logic [15:0] OVER_LIM = OV_RST, UNDER_LIM = UV_RST, PACK_VOLT_CTRL = 16'h8000;
	logic [15:0] PACK_VOLT_INTERNAL, r;
	logic [3:0] ADDR = 4'h0;
	logic [31:0] WDATA = 32'h0, RDATA, RDATA2;
	logic [32:0] exp_q[$];
	int mismatches = 0, checked = 0, cycles = 0, hi;
	pack_guard_if link();
	pack_guard_if stub();
	assign stub.layer_open = 1'h0;
	assign stub.sense_alert_irq = 1'h0;
	assign stub.ctrl_reset_n = 1'h1;
	assign stub.pack_volt_fine = 20'(cycles);
	pack_monitor #(.WDOG_COUNT(WD)) pack_monitor_i (.CORE_CLK, .RESETN, .LINK(link.monitor),
		.ADC_RAW, .OVER_LIM, .UNDER_LIM, .IRQ_CLEAR, .LAYER_OPEN, .PACK_VOLT_INTERNAL);
	pack_controller #(.WAIT_COUNT(20)) pack_controller_i (.CORE_CLK, .RESETN,
		.LINK(link.ctrl), .PACK_VOLT_CTRL, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ, .HEATER_PWM);
	pack_controller #(.WAIT_COUNT(20)) pack_controller_i2 (.CORE_CLK, .RESETN,
		.LINK(stub.ctrl), .PACK_VOLT_CTRL, .ADDR, .WDATA, .WR, .RD, .RDATA(RDATA2), .IRQ(IRQ2),
		.HEATER_PWM(HEATER_PWM2));
	pack_guard_chk #(.WDOG_COUNT(WD)) pack_guard_chk_i (.CORE_CLK, .RESETN,
		.protect_request_a(link.protect_request_a), .protect_request_b(link.protect_request_b),
		.fuse_blow_cmd(link.fuse_blow_cmd), .sense_alert_irq(link.sense_alert_irq),
		.ctrl_reset_n(link.ctrl_reset_n), .monitor_reset_n(link.monitor_reset_n),
		.heartbeat(link.heartbeat), .layer_open(link.layer_open));
	initial forever #50 CORE_CLK = ~CORE_CLK;
	// read data are compared one cycle after the strobe
	always @(posedge CORE_CLK) begin
		logic [32:0] t;
		cycles <= cycles + 1;
		rd_q <= RD;
		if (rd_q) begin
			t = exp_q.pop_front();
			`CHK(t[32] ? RDATA2 : RDATA, t[31:0])
		end
		if (cycles == 20000) begin
			mismatches++;
			results();
		end
	end
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'h1;
		@(posedge CORE_CLK);
		WR <= 1'h0;
	endtask
	task automatic rd(input logic s, input logic [3:0] a, input logic [31:0] e);
		@(posedge CORE_CLK);
		ADDR <= a;
		RD <= 1'h1;
		exp_q.push_back({s, e});
		@(posedge CORE_CLK);
		RD <= 1'h0;
	endtask
	task automatic rst();
		@(posedge CORE_CLK);
		RESETN <= 1'h0;
		repeat (4) @(posedge CORE_CLK);
		RESETN <= 1'h1;
		repeat (3) @(posedge CORE_CLK);
	endtask
	task automatic results();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h1f8b));
		rst();
		rd(1'h0, 4'h0, 32'hf000);
		rd(1'h0, 4'h2, 32'hff);
		rd(1'h0, 4'h4, 32'h0);
		wr(4'h9, 32'hffff);
		rd(1'h0, 4'h9, 32'h0);
		r = 16'($urandom_range(32'hfff));
		wr(4'h1, {16'h0, r});
		rd(1'h0, 4'h1, {16'h0, r});
		@(posedge CORE_CLK);
		ADC_RAW <= {16'($urandom_range(32'he800, 32'h1800)), 4'($urandom)};
		PACK_VOLT_CTRL <= 16'($urandom_range(32'he800, 32'h1800));
		repeat (40) @(negedge CORE_CLK);
		`CHK(PACK_VOLT_INTERNAL, ADC_RAW[19:4])
		`CHK({LAYER_OPEN, link.protect_request_a}, 2'h1)
		rd(1'h0, 4'h7, {12'h0, ADC_RAW});
		for (int k = 0; k < 2; k++) begin
			rst();
			@(posedge CORE_CLK);
			ADC_RAW <= k ? 20'hf8000 : 20'h08000;
			`WAITV(LAYER_OPEN, 1'h1, 40)
			`CHK({LAYER_OPEN, link.sense_alert_irq}, 2'h3)
			@(posedge CORE_CLK);
			ADC_RAW <= 20'h80000;
			repeat (40) @(posedge CORE_CLK);
			IRQ_CLEAR <= 1'h1;
			@(posedge CORE_CLK);
			IRQ_CLEAR <= 1'h0;
			repeat (3) @(negedge CORE_CLK);
			`CHK(link.sense_alert_irq, 1'h0)
			rst();
			@(posedge CORE_CLK);
			PACK_VOLT_CTRL <= k ? 16'hf800 : 16'h0800;
			`WAITV(link.protect_request_a, 1'h0, 6)
			`CHK({link.protect_request_a, link.protect_request_b}, 2'h0)
			`WAITV(LAYER_OPEN, 1'h1, 10)
			`CHK(LAYER_OPEN, 1'h1)
			@(posedge CORE_CLK);
			PACK_VOLT_CTRL <= 16'h8000;
			repeat (40) @(negedge CORE_CLK);
			`CHK({link.fuse_blow_cmd, HEATER_PWM, stub.fuse_blow_cmd}, 3'h1)
			`CHK({link.protect_request_a, HEATER_PWM2}, 2'h1)
			rd(1'h1, 4'h4, 32'h3);
			rd(1'h1, 4'h8, 32'h2);
			wr(4'h6, 32'h2);
			repeat (2) @(negedge CORE_CLK);
			`CHK({IRQ, IRQ2}, 2'h1)
			wr(4'h5, 32'h2);
			repeat (2) @(negedge CORE_CLK);
			`CHK(IRQ2, 1'h0)
			wr(4'h2, 32'h80);
			hi = 0;
			repeat (512) begin
				@(negedge CORE_CLK);
				hi += int'(HEATER_PWM2 === 1'h1);
			end
			`CHK(hi >= 255 && hi <= 257, 1'h1)
		end
		rst();
		wr(4'h3, 32'h2);
		`WAITV(LAYER_OPEN, 1'h1, 10)
		`CHK({link.monitor_reset_n, LAYER_OPEN}, 2'h1)
		rst();
		wr(4'h3, 32'h1);
		wr(4'h3, 32'h0);
		`WAITV(link.ctrl_reset_n, 1'h0, WD + 100)
		`CHK(link.ctrl_reset_n, 1'h0)
		repeat (4) @(posedge CORE_CLK);
		results();
	end
endmodule
